// ===== inc/frap_cfg.svh
`ifndef FRAP_CFG_SVH
`define FRAP_CFG_SVH

// fuse map positions
`define FRAP_FUSE_COUNT       128
`define FRAP_FUSE_SBE_BIT     7'd1
`define FRAP_FUSE_LOCK_BIT    7'd87
`define FRAP_FUSE_READ_LO     7'd64
`define FRAP_FUSE_MAKER_LO    7'd88
`define FRAP_FUSE_STATUS_LO   7'd64
`define FRAP_FUSE_STATUS_HI   7'd86

// wishbone register offsets (byte addresses)
`define FRAP_REG_CTRL         4'h0
`define FRAP_REG_STATUS       4'h4
`define FRAP_REG_DATA         4'h8
`define FRAP_REG_INDEX        4'hc

// control field positions
`define FRAP_CTRL_GO          0
`define FRAP_CTRL_CMD_LO      1
`define FRAP_CTRL_CMD_HI      3

// reset values
`define FRAP_FUSE_RESET       128'hffff_ffff_ffff_ffff_ffff_ffff_ffff_ffff
`define FRAP_ROM_MAKER_ID     16'h5a5a // arbitrary value
`define FRAP_ROM_SERIAL       16'h1234 // arbitrary value
`define FRAP_ROM_REVISION     32'h0000_0001 // arbitrary value
`define FRAP_FUSE_MAKER_ID    8'ha5 // arbitrary value
`define FRAP_FUSE_SERIAL      32'h0bad_cafe // arbitrary value

// watchdog interval (ms) and cycle count at 50 mhz
`define FRAP_WDOG_MS          1300
`define FRAP_CLK_KHZ          50000
`define FRAP_WDOG_CYCLES      (`FRAP_WDOG_MS * `FRAP_CLK_KHZ)

`endif

// ===== inc/frap_pkg.sv
package frap_pkg;

	// host command codes carried in the control register
	typedef enum logic [2:0] {
		FRAP_CMD_READ_FUSE  = 3'h0,
		FRAP_CMD_READ_ROM   = 3'h1,
		FRAP_CMD_SINGLE     = 3'h2,
		FRAP_CMD_PERSONAL   = 3'h3,
		FRAP_CMD_DIGEST     = 3'h4
	} frap_cmd_t;

	// command status codes
	typedef enum logic [1:0] {
		FRAP_ST_OK     = 2'h0,
		FRAP_ST_DENIED = 2'h1,
		FRAP_ST_BADCMD = 2'h2
	} frap_status_t;

	// sequencer states
	typedef enum logic [3:0] {
		FRAP_IDLE  = 4'b0001,
		FRAP_EXEC  = 4'b0010,
		FRAP_DONE  = 4'b0100,
		FRAP_SLEEP = 4'b1000
	} frap_state_t;

endpackage

// ===== core/frap_fuse_array.sv
`timescale 1ns/10ps
`include "frap_cfg.svh"

// one-time fuse store: bits only ever go from one to zero
module frap_fuse_array (
	// clock and reset
	input  wire logic         i_core_clk,
	input  wire logic         i_rst,
	// burn request
	input  wire logic         i_burn,
	input  wire logic [127:0] i_burn_mask,
	// stored state
	output logic      [127:0] o_fuses
);
	logic [127:0] fuse_q;

	// reset models factory state; and-only update means no way back to one
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			fuse_q <= {`FRAP_FUSE_SERIAL, `FRAP_FUSE_MAKER_ID,
				88'hff_ffff_ffff_ffff_ffff_ffff};
		end else if (i_burn) begin
			fuse_q <= fuse_q & ~i_burn_mask;
		end
	end

	assign o_fuses = fuse_q;
endmodule

// ===== core/frap_watchdog.sv
`timescale 1ns/10ps
`include "frap_cfg.svh"

// free-running watchdog; expiry is a one-cycle pulse
module frap_watchdog #(
	parameter int unsigned WDOG_CYCLES = `FRAP_WDOG_CYCLES
) (
	// clock and reset
	input  wire logic i_core_clk,
	input  wire logic i_rst,
	// restart from wake
	input  wire logic i_restart,
	// expiry pulse
	output logic      o_expire
);
	logic [31:0] count;

	// ignores command activity on purpose: a stuck host cannot hold it off
	always_ff @(posedge i_core_clk) begin
		if (i_rst || i_restart) begin
			count    <= 32'h0;
			o_expire <= 1'b0;
		end else if (count == WDOG_CYCLES - 1) begin
			count    <= 32'h0;
			o_expire <= 1'b1;
		end else begin
			count    <= count + 32'h1;
			o_expire <= 1'b0;
		end
	end
endmodule

// ===== core/frap_policy.sv
`timescale 1ns/10ps
`include "frap_cfg.svh"

module frap_policy
	import frap_pkg::*;
#(
	parameter int unsigned WDOG_CYCLES = `FRAP_WDOG_CYCLES
) (
	// clock and reset
	input  wire logic         i_core_clk,
	input  wire logic         i_rst,
	// wishbone slave
	input  wire logic         i_wb_cyc,
	input  wire logic         i_wb_stb,
	input  wire logic         i_wb_we,
	input  wire logic [3:0]   i_wb_adr,
	input  wire logic [3:0]   i_wb_sel,
	input  wire logic [31:0]  i_wb_dat,
	output logic      [31:0]  o_wb_dat,
	output logic              o_wb_ack,
	// link wake from the single-wire front end
	input  wire logic         i_wake,
	// digest message fields toward the hash engine
	output logic      [127:0] o_digest_fuses,
	output logic      [63:0]  o_secret_for_key,
	output logic      [47:0]  o_chip_serial,
	output logic      [23:0]  o_maker_id,
	// power state
	output logic              o_sleep
);
	// registers
	logic [31:0]  data_reg;
	logic [6:0]   index_reg;
	logic [2:0]   cmd_reg;
	logic [1:0]   status_reg;
	logic         busy;
	frap_state_t  state;
	frap_state_t  next_state;
	logic [127:0] mask_hi_lo;
	logic         burn_go;
	logic [127:0] burn_mask;
	logic [127:0] fuses;
	logic         wd_expire;

	// wishbone decode
	wire         wb_req    = i_wb_cyc & i_wb_stb & ~o_wb_ack;
	wire         wr_req    = wb_req & i_wb_we;
	wire         wr_ctrl   = wr_req & (i_wb_adr == `FRAP_REG_CTRL) & i_wb_sel[0];
	wire         wr_data   = wr_req & (i_wb_adr == `FRAP_REG_DATA);
	wire         wr_index  = wr_req & (i_wb_adr == `FRAP_REG_INDEX)
		& i_wb_sel[0];
	wire         go        = wr_ctrl & i_wb_dat[`FRAP_CTRL_GO] & ~busy
		& (state == FRAP_IDLE);
	wire [2:0]   go_cmd    = i_wb_dat[`FRAP_CTRL_CMD_HI:`FRAP_CTRL_CMD_LO];

	// fuse state flags
	wire         sbe_set   = fuses[`FRAP_FUSE_SBE_BIT];
	wire         lock_set  = fuses[`FRAP_FUSE_LOCK_BIT];

	// byte-lane merge for the data register
	function automatic logic [31:0] merge_lanes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] sel);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// word select of a 128-bit fuse image by a 2-bit word number
	function automatic logic [31:0] word_of(input logic [127:0] v,
		input logic [1:0] w);
		return v[w*32 +: 32];
	endfunction

	// fuse words 0-1 secret, words 2-3 readable
	wire [1:0]   rd_word    = index_reg[1:0];
	wire         fuse_rd_ok = (rd_word >= 2'd2);
	// rom: only words 0 and 1 (64 bits) exposed
	wire         rom_rd_ok  = (index_reg <= 7'd1);
	wire [31:0]  rom_word   = (index_reg[0] == 1'b0)
		? {`FRAP_ROM_SERIAL, `FRAP_ROM_MAKER_ID}
		: `FRAP_ROM_REVISION;

	// burnable ranges per command, factory bits 88-127 never
	assign mask_hi_lo = {40'h0, 1'b1, {87{1'b1}}};
	wire [127:0] pers_mask  = {96'h0, data_reg} << {index_reg[1:0], 5'h0};
	wire [127:0] pers_bad   = pers_mask & ~mask_hi_lo;
	wire         single_in  = (index_reg >= `FRAP_FUSE_STATUS_LO)
		&& (index_reg <= `FRAP_FUSE_STATUS_HI);
	wire [127:0] single_bit = 128'h1 << index_reg;

	// single burn: enable fuse one, status index only
	wire         single_ok  = sbe_set & single_in;
	// personalization: lock fuse unburned, no factory bit touched
	wire         pers_ok    = lock_set & (pers_bad == 128'h0);

	// burn request to the fuse store, only from an allowed command
	assign burn_go = (state == FRAP_EXEC) & (
		((cmd_reg == FRAP_CMD_SINGLE) & single_ok) |
		((cmd_reg == FRAP_CMD_PERSONAL) & pers_ok));
	assign burn_mask = (cmd_reg == FRAP_CMD_SINGLE) ? single_bit : pers_mask;

	frap_fuse_array u_fuses (
		.i_core_clk  (i_core_clk),
		.i_rst       (i_rst),
		.i_burn      (burn_go),
		.i_burn_mask (burn_mask),
		.o_fuses     (fuses)
	);

	frap_watchdog #(
		.WDOG_CYCLES (WDOG_CYCLES)
	) u_wdog (
		.i_core_clk  (i_core_clk),
		.i_rst       (i_rst),
		.i_restart   (i_wake),
		.o_expire    (wd_expire)
	);

	// sequencer next-state
	always_comb begin
		next_state = state;
		unique case (state)
			FRAP_IDLE:  if (go) next_state = FRAP_EXEC;
			FRAP_EXEC:  next_state = FRAP_DONE;
			FRAP_DONE:  next_state = FRAP_IDLE;
			FRAP_SLEEP: if (i_wake) next_state = FRAP_IDLE;
		endcase
		// watchdog wins over any command in flight
		if (wd_expire) next_state = FRAP_SLEEP;
	end

	// state register
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			state <= FRAP_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// command latch and busy flag
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			cmd_reg <= 3'h0;
			busy    <= 1'b0;
		end else if (go) begin
			cmd_reg <= go_cmd;
			busy    <= 1'b1;
		end else if (next_state == FRAP_IDLE || next_state == FRAP_SLEEP) begin
			busy    <= 1'b0;
		end
	end

	// index register
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			index_reg <= 7'h0;
		end else if (wr_index && !busy) begin
			index_reg <= i_wb_dat[6:0];
		end
	end

	// data register: host writes it, reads fill it on success
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			data_reg <= 32'h0;
		end else if (state == FRAP_EXEC && cmd_reg == FRAP_CMD_READ_FUSE) begin
			if (fuse_rd_ok) data_reg <= word_of(fuses, rd_word);
		end else if (state == FRAP_EXEC && cmd_reg == FRAP_CMD_READ_ROM) begin
			if (rom_rd_ok) data_reg <= rom_word;
		end else if (wr_data && !busy) begin
			data_reg <= merge_lanes(data_reg, i_wb_dat, i_wb_sel);
		end
	end

	// command outcome; a refused command sets DENIED and leaves fuses and data unchanged
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			status_reg <= FRAP_ST_OK;
		end else if (state == FRAP_EXEC) begin
			unique case (cmd_reg)
				FRAP_CMD_READ_FUSE: status_reg <= fuse_rd_ok
					? FRAP_ST_OK : FRAP_ST_DENIED;
				FRAP_CMD_READ_ROM:  status_reg <= rom_rd_ok
					? FRAP_ST_OK : FRAP_ST_DENIED;
				FRAP_CMD_SINGLE:    status_reg <= single_ok
					? FRAP_ST_OK : FRAP_ST_DENIED;
				FRAP_CMD_PERSONAL:  status_reg <= pers_ok
					? FRAP_ST_OK : FRAP_ST_DENIED;
				FRAP_CMD_DIGEST:    status_reg <= FRAP_ST_OK;
				default:            status_reg <= FRAP_ST_BADCMD;
			endcase
		end
	end

	// digest message view: ones for 0-86 while lock fuse unburned
	wire [127:0] digest_view = lock_set
		? (fuses | {41'h0, {87{1'b1}}})
		: fuses;

	// hash-side fields, registered so outputs come from flip-flops
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_digest_fuses   <= 128'h0;
			o_secret_for_key <= 64'h0;
			o_chip_serial    <= 48'h0;
			o_maker_id       <= 24'h0;
			o_sleep          <= 1'b0;
		end else begin
			o_digest_fuses   <= digest_view;
			o_secret_for_key <= digest_view[63:0];
			o_chip_serial    <= {`FRAP_ROM_SERIAL, fuses[127:96]};
			o_maker_id       <= {`FRAP_ROM_MAKER_ID, fuses[95:88]};
			o_sleep          <= (next_state == FRAP_SLEEP);
		end
	end

	// bus read mux
	wire [31:0] status_word = {26'h0, sbe_set, lock_set, busy,
		status_reg, 1'b0};
	wire [31:0] rd_mux =
		(i_wb_adr == `FRAP_REG_CTRL)   ? {28'h0, cmd_reg, 1'b0} :
		(i_wb_adr == `FRAP_REG_STATUS) ? status_word :
		(i_wb_adr == `FRAP_REG_DATA)   ? data_reg :
		(i_wb_adr == `FRAP_REG_INDEX)  ? {25'h0, index_reg} : 32'h0;

	// single-cycle ack, dropped the cycle after; unmapped reads zero
	always_ff @(posedge i_core_clk) begin
		if (i_rst) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0;
		end else begin
			o_wb_ack <= wb_req;
			o_wb_dat <= wb_req ? rd_mux : 32'h0;
		end
	end
endmodule

// ===== verification/frap_policy_asserts.sv
`timescale 1ns/10ps
`include "frap_cfg.svh"

// watches the policy block pins only
module frap_policy_asserts #(
	parameter int unsigned WDOG_CYCLES = `FRAP_WDOG_CYCLES
) (
	// clock and reset
	input  wire logic         i_core_clk,
	input  wire logic         i_rst,
	// wishbone and wake
	input  wire logic         i_wb_cyc,
	input  wire logic         i_wb_stb,
	input  wire logic         i_wb_we,
	input  wire logic [3:0]   i_wb_adr,
	input  wire logic [3:0]   i_wb_sel,
	input  wire logic [31:0]  i_wb_dat,
	input  wire logic [31:0]  o_wb_dat,
	input  wire logic         o_wb_ack,
	input  wire logic         i_wake,
	// digest side and power
	input  wire logic [127:0] o_digest_fuses,
	input  wire logic [63:0]  o_secret_for_key,
	input  wire logic [47:0]  o_chip_serial,
	input  wire logic [23:0]  o_maker_id,
	input  wire logic         o_sleep
);
	logic [31:0] idle_cnt;

	// cycles since wake or reset; saturates so it never wraps
	always_ff @(posedge i_core_clk) begin
		if (i_rst || i_wake)
			idle_cnt <= 32'h0;
		else if (idle_cnt != 32'hffff_ffff)
			idle_cnt <= idle_cnt + 32'h1;
	end

	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	property p_ack_next;
		i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack;
	endproperty
	a_ack_next: assert property (p_ack_next)
		else $error("ack missing after request");
	property p_ack_pulse;
		o_wb_ack |=> !o_wb_ack;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("ack longer than one cycle");
	property p_dat_idle;
		!o_wb_ack |-> o_wb_dat == 32'h0;
	endproperty
	a_dat_idle: assert property (p_dat_idle)
		else $error("read data outside ack");
	property p_lock_ones;
		o_digest_fuses[87] |-> &o_digest_fuses[86:0];
	endproperty
	a_lock_ones: assert property (p_lock_ones)
		else $error("digest shows real fuses while unlocked");
	property p_lock_stays;
		!$past(i_rst) && !o_digest_fuses[87] |=> !o_digest_fuses[87];
	endproperty
	a_lock_stays: assert property (p_lock_stays)
		else $error("lock fuse returned to one");
	property p_secret;
		o_secret_for_key == o_digest_fuses[63:0];
	endproperty
	a_secret: assert property (p_secret)
		else $error("key secret differs from digest image");
	property p_maker;
		!$past(i_rst) |->
			o_maker_id == {`FRAP_ROM_MAKER_ID, `FRAP_FUSE_MAKER_ID};
	endproperty
	a_maker: assert property (p_maker)
		else $error("maker id wrong");
	property p_serial;
		!$past(i_rst) |->
			o_chip_serial == {`FRAP_ROM_SERIAL, `FRAP_FUSE_SERIAL};
	endproperty
	a_serial: assert property (p_serial)
		else $error("chip serial wrong");
	property p_wdog;
		idle_cnt >= WDOG_CYCLES + 4 |-> o_sleep;
	endproperty
	a_wdog: assert property (p_wdog)
		else $error("no sleep after watchdog interval");
endmodule

bind frap_policy frap_policy_asserts #(.WDOG_CYCLES(WDOG_CYCLES)) u_chk (
	.i_core_clk       (i_core_clk),
	.i_rst            (i_rst),
	.i_wb_cyc         (i_wb_cyc),
	.i_wb_stb         (i_wb_stb),
	.i_wb_we          (i_wb_we),
	.i_wb_adr         (i_wb_adr),
	.i_wb_sel         (i_wb_sel),
	.i_wb_dat         (i_wb_dat),
	.o_wb_dat         (o_wb_dat),
	.o_wb_ack         (o_wb_ack),
	.i_wake           (i_wake),
	.o_digest_fuses   (o_digest_fuses),
	.o_secret_for_key (o_secret_for_key),
	.o_chip_serial    (o_chip_serial),
	.o_maker_id       (o_maker_id),
	.o_sleep          (o_sleep)
);

// ===== verification/frap_host.sv
`timescale 1ns/10ps

// host model: classic wishbone master, one request at a time
module frap_host (
	// clock
	input  wire logic        i_core_clk,
	// wishbone master
	output logic             o_cyc,
	output logic             o_stb,
	output logic             o_we,
	output logic [3:0]       o_adr,
	output logic [3:0]       o_sel,
	output logic [31:0]      o_dat,
	input  wire logic        i_ack,
	input  wire logic [31:0] i_dat,
	// link wake
	output logic             o_wake
);
	// idle bus at time zero
	initial begin
		o_cyc = 1'b0;
		o_stb = 1'b0;
		o_we = 1'b0;
		o_adr = 4'h0;
		o_sel = 4'h0;
		o_dat = 32'h0;
		o_wake = 1'b0;
	end

	// request held until ack is sampled
	task automatic xfer(input logic w, input logic [3:0] a,
		input logic [31:0] v, output logic [31:0] r);
		@(posedge i_core_clk);
		o_cyc <= 1'b1;
		o_stb <= 1'b1;
		o_we <= w;
		o_adr <= a;
		o_sel <= 4'hf;
		o_dat <= v;
		o_wake <= 1'b1;
		// no cycle count assumed; only the bench timeout ends a hang
		do begin
			@(posedge i_core_clk);
		end while (i_ack !== 1'b1);
		r = i_dat;
		o_cyc <= 1'b0;
		o_stb <= 1'b0;
		o_wake <= 1'b0;
		o_dat <= ~v; // no stale data once released
	endtask
endmodule

// ===== verification/testbench.sv
`timescale 1ns/10ps
`include "frap_cfg.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
	$display("wrong value at %0t: %h not %h", $time, a, b); end end

module testbench;
	import frap_pkg::*;
	logic         i_core_clk = 1'b0;
	logic         i_rst = 1'b1;
	logic         cyc, stb, we, wake, ack, sleep;
	logic [3:0]   adr, sel;
	logic [31:0]  wdat, rdat, d;
	logic [127:0] dig;
	logic [63:0]  key;
	logic [47:0]  ser;
	logic [23:0]  mid;
	int           errors = 0;
	int           num_checks = 0;

	always #10 i_core_clk = ~i_core_clk;

	// short watchdog keeps the sleep test brief
	frap_policy #(.WDOG_CYCLES(200)) dut (.i_core_clk(i_core_clk),
		.i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
		.i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
		.o_wb_ack(ack), .i_wake(wake), .o_digest_fuses(dig),
		.o_secret_for_key(key), .o_chip_serial(ser), .o_maker_id(mid),
		.o_sleep(sleep));
	frap_host host (.i_core_clk(i_core_clk), .o_cyc(cyc), .o_stb(stb),
		.o_we(we), .o_adr(adr), .o_sel(sel), .o_dat(wdat), .i_ack(ack),
		.i_dat(rdat), .o_wake(wake));

	task automatic give_verdict;
		if (errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// index, data, go; poll busy; compare status field
	task automatic run(input logic [2:0] c, input logic [31:0] idx,
		input logic [31:0] dv, input logic [1:0] s);
		int n;
		host.xfer(1'b1, 4'hc, idx, d);
		host.xfer(1'b1, 4'h8, dv, d);
		host.xfer(1'b1, 4'h0, {28'h0, c, 1'b1}, d);
		n = 0;
		do begin
			host.xfer(1'b0, 4'h4, 32'h0, d);
			n++;
		end while (d[3] !== 1'b0 && n < 50);
		`CHK(d[3], 1'b0)
		`CHK(d[2:1], s)
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
		host.xfer(1'b0, a, 32'h0, d);
		`CHK(d, e)
	endtask

	// hang guard
	initial begin
		repeat (20000) @(posedge i_core_clk);
		errors++;
		give_verdict();
	end

	initial begin
		repeat (16) @(posedge i_core_clk);
		i_rst <= 1'b0;
		repeat (230) @(posedge i_core_clk);
		`CHK(sleep, 1'b1)
		rd_chk(4'h2, 32'h0);
		rd_chk(4'h4, 32'h30);
		`CHK(ser, {`FRAP_ROM_SERIAL, `FRAP_FUSE_SERIAL})
		`CHK(mid, {`FRAP_ROM_MAKER_ID, `FRAP_FUSE_MAKER_ID})
		`CHK(key, {64{1'b1}})
		run(FRAP_CMD_READ_FUSE, 0, 32'h1357_9bdf, FRAP_ST_DENIED);
		rd_chk(4'h8, 32'h1357_9bdf);
		run(FRAP_CMD_READ_FUSE, 1, 0, FRAP_ST_DENIED);
		run(FRAP_CMD_READ_FUSE, 3, 0, FRAP_ST_OK);
		rd_chk(4'h8, `FRAP_FUSE_SERIAL);
		run(FRAP_CMD_READ_ROM, 0, 0, FRAP_ST_OK);
		rd_chk(4'h8, {`FRAP_ROM_SERIAL, `FRAP_ROM_MAKER_ID});
		run(FRAP_CMD_READ_ROM, 1, 0, FRAP_ST_OK);
		rd_chk(4'h8, `FRAP_ROM_REVISION);
		run(FRAP_CMD_READ_ROM, 2, 0, FRAP_ST_DENIED);
		rd_chk(4'hc, 32'h2);
		run(3'h5, 0, 0, FRAP_ST_BADCMD);
		rd_chk(4'h0, 32'ha);
		run(FRAP_CMD_SINGLE, 70, 0, FRAP_ST_OK);
		run(FRAP_CMD_SINGLE, 88, 0, FRAP_ST_DENIED);
		run(FRAP_CMD_SINGLE, 10, 0, FRAP_ST_DENIED);
		run(FRAP_CMD_SINGLE, 1, 0, FRAP_ST_DENIED);
		`CHK(dig[70], 1'b1)
		run(FRAP_CMD_READ_FUSE, 2, 0, FRAP_ST_OK);
		rd_chk(4'h8, 32'ha5ff_ffbf);
		run(FRAP_CMD_PERSONAL, 0, 32'h2, FRAP_ST_OK);
		rd_chk(4'h4, 32'h10);
		run(FRAP_CMD_SINGLE, 71, 0, FRAP_ST_DENIED);
		run(FRAP_CMD_PERSONAL, 3, 32'h1, FRAP_ST_DENIED);
		run(FRAP_CMD_PERSONAL, 2, 32'h0080_0000, FRAP_ST_OK);
		rd_chk(4'h4, 32'h0);
		run(FRAP_CMD_DIGEST, 0, 0, FRAP_ST_OK);
		`CHK(dig[87:0], 88'h7f_ffbf_ffff_ffff_ffff_fffd)
		`CHK(key, 64'hffff_ffff_ffff_fffd)
		run(FRAP_CMD_PERSONAL, 0, 32'h4, FRAP_ST_DENIED);
		run(FRAP_CMD_READ_FUSE, 2, 0, FRAP_ST_OK);
		rd_chk(4'h8, 32'ha57f_ffbf);
		give_verdict();
	end
endmodule
